// ---- core/dpl_loader.sv ----
// Programme loader, mode decoder and swallow strobe generator of the divider.
`timescale 1ns/1ps
module dpl_loader
    import dpl_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    // Programme interface
    input  wire logic       prog_step_clock,
    input  wire logic       prog_scan_enable,
    input  wire logic [3:0] operand_a_nibble,
    input  wire logic [3:0] operand_b_nibble,
    input  wire logic       borrow_in,
    output logic      [6:0] fetch_strobe_n,
    // Divider input and cascade
    input  wire logic       divider_in,
    input  wire logic       cascade_feedback_in,
    // Divider outputs
    output logic            swallow_sync,
    output logic            swallow_strobe_first,
    output logic            swallow_strobe_second,
    output logic            swallow_strobe_third,
    output logic            fast_divided_out,
    output logic            slow_divided_out,
    // Status
    output logic            slave_mode,
    output logic      [3:0] nibble_counter_prog
);

    ////////////////////////////////////////////////////////////////////////////////
    dpl_pins_s pins_raw;
    dpl_pins_s pins;
    logic      step_prev_q;
    logic      div_prev_q;
    logic      step_rise;
    logic      step_fall;
    logic      in_tick;

    assign pins_raw = '{step_clk: prog_step_clock, scan_en: prog_scan_enable,
                        op_a_n: operand_a_nibble, op_b_n: operand_b_nibble,
                        borrow_in: borrow_in, cascade_n: cascade_feedback_in,
                        div_in: divider_in};

    dpl_sync #(.WIDTH($bits(dpl_pins_s))) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .async_in (pins_raw),
        .sync_out (pins)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            step_prev_q <= 1'b0;
            div_prev_q  <= 1'b0;
        end else if (clk_en) begin
            step_prev_q <= pins.step_clk;
            div_prev_q  <= pins.div_in;
        end
    end

    assign step_rise = clk_en && pins.step_clk && !step_prev_q;
    assign step_fall = clk_en && !pins.step_clk && step_prev_q;
    assign in_tick   = clk_en && pins.div_in && !div_prev_q;

    ////////////////////////////////////////////////////////////////////////////////
    dpl_pc_e pc_q;
    dpl_pc_e pc_d;

    always_comb begin
        pc_d = pc_q;
        if (!pins.scan_en) begin
            pc_d = PC_F6;
        end else if (step_rise) begin
            pc_d = dpl_pc_e'(pc_q + 3'd1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pc_q           <= PC_F6;
            fetch_strobe_n <= ~(7'h01 << PC_F6);
        end else if (clk_en) begin
            pc_q           <= pc_d;
            fetch_strobe_n <= (pc_d == PC_IDLE) ? DPL_STRB_IDLE
                            : ~(7'h01 << pc_d);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Active-low operand pins become plain BCD values here.
    logic [3:0] op_a;
    logic [3:0] op_b;
    logic       bor_q;
    logic       bor_sel;
    logic [4:0] diff;
    logic       bor_out;
    logic [3:0] dig_new;
    logic [3:0] dig_q [DPL_DIGITS];
    logic [5:2] zero_ok_q;
    logic       slave_bor_q;
    dpl_mode_s  mode_q;

    assign op_a    = ~pins.op_a_n;
    assign op_b    = ~pins.op_b_n;
    assign bor_sel = (pc_q == PC_F0) ? pins.borrow_in : bor_q;
    assign diff    = {1'b0, op_a} - {1'b0, op_b} - {4'h0, bor_sel};
    assign bor_out = diff[4];
    assign dig_new = bor_out ? 4'((diff + DPL_BCD_BASE) & 5'h0F) : diff[3:0];

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bor_q       <= 1'b0;
            slave_bor_q <= 1'b0;
        end else if (step_fall && pc_q < PC_F6) begin
            bor_q <= bor_out;
            if (pc_q == dpl_pc_e'(DPL_BORROW_DIGIT)) begin
                slave_bor_q <= bor_out;
            end
        end
    end

    // Each digit is written only in its own fetch period and otherwise holds.
    for (genvar k = 0; k < DPL_DIGITS; k++) begin : g_digit
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                dig_q[k] <= DPL_DIG_RESET;
            end else if (step_fall && pc_q == dpl_pc_e'(k)) begin
                dig_q[k] <= dig_new;
            end
        end
        if (k >= DPL_LZ_LOW) begin : g_slave
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    zero_ok_q[k] <= 1'b0;
                end else if (step_fall && pc_q == dpl_pc_e'(k)) begin
                    zero_ok_q[k] <= (k == DPL_LZ_LOW) ?
                        (op_a == DPL_SLAVE_A && op_b == DPL_SLAVE_B) :
                        (op_a == DPL_DIG_RESET && op_b == DPL_DIG_RESET);
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_q <= '{m_ratio: DPL_M_RESET, hc_enable: 1'b0, hc_select: 1'b0,
                        dm_mode: 2'b00};
        end else if (step_fall && pc_q == dpl_pc_e'(DPL_CTRL_FETCH)) begin
            mode_q.m_ratio   <= (op_a == DPL_DIG_RESET) ? DPL_M_RESET
                              : {1'b0, op_a};
            mode_q.hc_enable <= op_b[0];
            mode_q.hc_select <= op_b[1];
            mode_q.dm_mode   <= op_b[3:2];
        end
    end

    assign slave_mode = &zero_ok_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Leading-zero detector; an all-zero upper programme leaves the counter at one.
    int         lz;
    logic [3:0] c1_prog;
    logic [3:0] dig_c1fb;
    logic [3:0] dig_c0fb;

    always_comb begin
        lz = DPL_LZ_LOW;
        for (int j = DPL_LZ_LOW; j <= DPL_LZ_HIGH; j++) begin
            if (dig_q[j] != DPL_DIG_RESET) begin
                lz = j;
            end
        end
        c1_prog  = (dig_q[lz] == DPL_DIG_RESET) ? DPL_C1_DEFAULT : dig_q[lz];
        dig_c1fb = dig_q[lz - 1];
        dig_c0fb = dig_q[lz - 2];
    end

    assign nibble_counter_prog = c1_prog;

    ////////////////////////////////////////////////////////////////////////////////
    // Counter chain on the sampled divider input: dual-modulus, nibble, decade, final.
    logic [3:0] dm_q;
    logic [3:0] c1_q;
    logic [3:0] dec_q;
    logic [4:0] fin_q;
    logic [3:0] dm_lim;
    logic [3:0] c1_lim;
    logic       dm_tick;
    logic       c1_tick;
    logic       fast_tick;
    logic       fin_tick;
    logic       half_q;
    logic       slow_tick;

    always_comb begin
        case (mode_q.dm_mode)
            2'd0:    dm_lim = 4'd0;
            2'd1:    dm_lim = 4'd1;
            2'd2:    dm_lim = 4'd4;
            default: dm_lim = DPL_BCD_MAX + 4'(dec_q < dig_c0fb);
        endcase
    end

    assign c1_lim    = c1_prog - 4'd1 + 4'(dec_q < dig_c1fb);
    assign dm_tick   = slave_mode ? in_tick : (in_tick && dm_q >= dm_lim);
    assign c1_tick   = slave_mode ? in_tick : (dm_tick && c1_q >= c1_lim);
    assign fast_tick = c1_tick && dec_q == DPL_BCD_MAX;
    assign fin_tick  = fast_tick && fin_q >= mode_q.m_ratio - 5'd1;
    assign slow_tick = fin_tick && (half_q || !mode_q.hc_enable);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dm_q <= DPL_CNT_RESET;
        end else if (dm_tick || slave_mode) begin
            dm_q <= DPL_CNT_RESET;
        end else if (in_tick) begin
            dm_q <= dm_q + 4'd1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            c1_q <= DPL_CNT_RESET;
        end else if (c1_tick || slave_mode) begin
            c1_q <= DPL_CNT_RESET;
        end else if (dm_tick) begin
            c1_q <= c1_q + 4'd1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dec_q <= DPL_CNT_RESET;
            fin_q <= 5'h00;
            half_q <= 1'b0;
        end else if (c1_tick) begin
            dec_q <= fast_tick ? DPL_CNT_RESET : dec_q + 4'd1;
            if (fast_tick) begin
                fin_q <= fin_tick ? 5'h00 : fin_q + 5'd1;
            end
            if (fin_tick && mode_q.hc_enable) begin
                half_q <= !half_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per basic period swallow decisions. Digit zero works as a fraction over m.
    logic [4:0] frac_q;
    logic [3:0] pace_q;
    logic [2:0] fb_hit;
    logic       hc_hit;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            frac_q <= 5'h00;
            pace_q <= DPL_CNT_RESET;
        end else if (slow_tick) begin
            frac_q <= (frac_q >= mode_q.m_ratio - 5'd1) ? 5'h00 : frac_q + 5'd1;
            pace_q <= (pace_q == DPL_BCD_MAX) ? DPL_CNT_RESET : pace_q + 4'd1;
        end
    end

    assign hc_hit = mode_q.hc_enable && mode_q.hc_select && half_q;

    // Strobe j serves the j-th external prescaler, fastest first.
    for (genvar j = 0; j < 3; j++) begin : g_fb
        always_comb begin
            fb_hit[j] = (lz - 3 - j >= 1) && (pace_q < dig_q[(lz - 3 - j) & 7]);
            if (j == 0) begin
                fb_hit[j] = fb_hit[j] || ({1'b0, dig_q[0]} > frac_q) || hc_hit
                         || !pins.cascade_n;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs are updated on input edges only, so the sync pulse is one input period.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            swallow_sync          <= 1'b1;
            swallow_strobe_first  <= 1'b1;
            swallow_strobe_second <= 1'b1;
            swallow_strobe_third  <= 1'b1;
            fast_divided_out      <= 1'b1;
            slow_divided_out      <= 1'b1;
        end else if (in_tick) begin
            swallow_sync     <= !slow_tick;
            fast_divided_out <= !fast_tick;
            slow_divided_out <= !slow_tick;
            if (slow_tick) begin
                swallow_strobe_first  <= !fb_hit[0];
                swallow_strobe_second <= !fb_hit[1];
                swallow_strobe_third  <= slave_mode ? !slave_bor_q : !fb_hit[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic [3:0] stop_cnt_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n || pins.scan_en || !clk_en) begin
            stop_cnt_q <= 4'd0;
        end else if (stop_cnt_q != 4'd15) begin
            stop_cnt_q <= stop_cnt_q + 4'd1;
        end
    end

    a_strobe_one_low: assert property ($countones(~fetch_strobe_n) <= 1)
        else $error("more than one fetch strobe low");
    a_scan_stop_hold: assert property (stop_cnt_q >= 4'd2 |-> fetch_strobe_n == 7'h3F)
        else $error("stopped scanner not on seventh strobe");
    a_ratio_sixteen: assert property (step_fall && pc_q == PC_F6 && op_a == 4'h0
                                      |=> mode_q.m_ratio == 5'h10)
        else $error("all-high ratio did not give sixteen");
    a_sync_one_input: assert property ($fell(swallow_sync) |-> !slow_divided_out)
        else $error("sync pulse not tied to slow output");
    a_sync_hold_low: assert property (!swallow_sync && !in_tick |=> !swallow_sync)
        else $error("sync pulse ended before the next input tick");
    a_fb_period_hold: assert property (!in_tick || !slow_tick |=> $stable(swallow_strobe_first))
        else $error("first strobe changed inside a basic period");
    a_slave_bypass: assert property (slave_mode && in_tick |-> c1_tick)
        else $error("slave mode did not bypass counters");
    a_slave_borrow: assert property (slave_mode && in_tick && slow_tick
                                     |=> swallow_strobe_third == !slave_bor_q)
        else $error("third strobe not borrow in slave mode");
    a_digit_hold: assert property (!(step_fall && pc_q == PC_F3) |=> $stable(dig_q[3]))
        else $error("digit three changed outside its fetch");
    a_c1_nonzero: assert property (nibble_counter_prog != 4'h0)
        else $error("nibble counter programmed to zero");

    c_full_scan: cover property (pc_q == PC_F0 ##[1:1000] pc_q == PC_IDLE);
    c_slave_entry: cover property ($rose(slave_mode));
    c_swallow_first: cover property ($fell(swallow_strobe_first));
    c_half_channel: cover property (hc_hit && slow_tick);

endmodule : dpl_loader

// ---- core/dpl_pkg.sv ----
// Shared constants and types of the divider programme loader.
package dpl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int       DPL_DIGITS       = 6;
    localparam int       DPL_FETCHES      = 7;
    localparam int       DPL_NIB_W        = 4;
    localparam int       DPL_SYNC_STAGES  = 2;
    localparam int       DPL_CTRL_FETCH   = 6;
    localparam int       DPL_BORROW_DIGIT = 1;
    localparam int       DPL_LZ_LOW       = 2;
    localparam int       DPL_LZ_HIGH      = 5;
    localparam int       DPL_SCAN_STOP_CY = 8;
    localparam logic [3:0] DPL_DIG_RESET  = 4'h0;
    localparam logic [3:0] DPL_BCD_MAX    = 4'h9;
    localparam logic [4:0] DPL_BCD_BASE   = 5'h0A;
    localparam logic [3:0] DPL_C1_DEFAULT = 4'h1;
    localparam logic [3:0] DPL_SLAVE_A    = 4'hB;
    localparam logic [3:0] DPL_SLAVE_B    = 4'hA;
    localparam logic [4:0] DPL_M_RESET    = 5'h10;
    localparam logic [3:0] DPL_CNT_RESET  = 4'h0;
    localparam logic [6:0] DPL_STRB_IDLE  = 7'h7F;

    ////////////////////////////////////////////////////////////////////////////////
    // Programme counter: seven fetch periods and one idle state.
    typedef enum logic [2:0] {
        PC_F0, PC_F1, PC_F2, PC_F3, PC_F4, PC_F5, PC_F6, PC_IDLE
    } dpl_pc_e;

    // Pin-side inputs, carried together through the synchroniser.
    typedef struct packed {
        logic       step_clk;
        logic       scan_en;
        logic [3:0] op_a_n;
        logic [3:0] op_b_n;
        logic       borrow_in;
        logic       cascade_n;
        logic       div_in;
    } dpl_pins_s;

    // Decoded mode control word.
    typedef struct packed {
        logic [4:0] m_ratio;
        logic       hc_enable;
        logic       hc_select;
        logic [1:0] dm_mode;
    } dpl_mode_s;

endpackage : dpl_pkg

// ---- core/dpl_sync.sv ----
// Two-stage synchroniser for a bundle of pin inputs.
`timescale 1ns/1ps
module dpl_sync
    import dpl_pkg::*;
#(
    parameter int WIDTH = 13
) (
    // Clock and control
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // The first stage is read only by the second; pins may change at any time.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : dpl_sync

// ---- verif/dpl_loader_test.sv ----
// Self-checking testbench of the divider programme loader.
`timescale 1ns/1ps
module dpl_loader_test;
    import dpl_pkg::*;

    logic        core_clk;
    logic        rst_n;
    logic        step_clk;
    logic        scan_en;
    logic        borrow_in;
    logic        cascade_n;
    logic        divider_in;
    logic        div_run;
    logic [1:0]  div_ph;
    logic [55:0] prog_table;
    logic [3:0]  op_a;
    logic [3:0]  op_b;
    logic [6:0]  strobe_n;
    logic        sync_n;
    logic        fb1_n;
    logic        fb2_n;
    logic        fb3_n;
    logic        fast_n;
    logic        slow_n;
    logic        slave;
    logic [3:0]  c1_prog;
    int          n_fail;
    int          tests_run;

    ////////////////////////////////////////////////////////////////////////////////
    dpl_loader dpl_loader_i (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
        .prog_step_clock(step_clk), .prog_scan_enable(scan_en),
        .operand_a_nibble(op_a), .operand_b_nibble(op_b), .borrow_in(borrow_in),
        .fetch_strobe_n(strobe_n), .divider_in(divider_in), .cascade_feedback_in(cascade_n),
        .swallow_sync(sync_n), .swallow_strobe_first(fb1_n), .swallow_strobe_second(fb2_n),
        .swallow_strobe_third(fb3_n), .fast_divided_out(fast_n), .slow_divided_out(slow_n),
        .slave_mode(slave), .nibble_counter_prog(c1_prog)
    );

    dpl_prog_source dpl_prog_source_i (
        .fetch_strobe_n(strobe_n), .prog_table(prog_table),
        .operand_a_nibble(op_a), .operand_b_nibble(op_b)
    );

    always #5 core_clk = ~core_clk;

    // Divider input ticks every four core cycles, keeping two cycles per phase.
    always @(negedge core_clk) begin
        if (div_run) begin
            div_ph     <= div_ph + 2'd1;
            divider_in <= div_ph[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp7(input string what, input logic [6:0] exp, input logic [6:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp7

    task automatic cmp_int(input string what, input int exp, input int got);
        tests_run++;
        if (got != exp) begin
            n_fail++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmp_int

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // One step period of 100 core cycles keeps the step clock at 1 MHz.
    task automatic step(output logic [6:0] seen);
        @(negedge core_clk);
        step_clk = 1'b1;
        repeat (50) @(negedge core_clk);
        seen = strobe_n;
        step_clk = 1'b0;
        repeat (50) @(negedge core_clk);
    endtask : step

    // Starting from the stopped seventh fetch, eight steps make one full pass.
    task automatic load(input logic [55:0] tbl);
        logic [6:0] s;
        prog_table = tbl;
        scan_en    = 1'b1;
        repeat (8) step(s);
        scan_en = 1'b0;
        repeat (5) @(negedge core_clk);
    endtask : load

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        cmp7("strobes", 7'h3F, strobe_n);
        cmp7("outputs", 7'h7F, {1'b1, sync_n, fb1_n, fb2_n, fb3_n, fast_n, slow_n});
        cmp7("slave", 7'h00, {6'h00, slave});
        cmp7("c1 prog", 7'h01, {3'h0, c1_prog});
        $display("test reset done, failures %0d", n_fail);
    endtask : t_reset

    task automatic t_scan_order;
        logic [6:0] s;
        prog_table = 56'h40_0070_6018_1586;
        scan_en    = 1'b1;
        step(s);
        cmp7("idle strobes", 7'h7F, s);
        for (int k = 0; k < 7; k++) begin
            step(s);
            cmp7("fetch strobe", ~(7'h01 << k), s);
        end
        scan_en = 1'b0;
        repeat (5) @(negedge core_clk);
        cmp7("c1 prog", 7'h07, {3'h0, c1_prog});
        cmp7("slave", 7'h00, {6'h00, slave});
        $display("test scan order done, failures %0d", n_fail);
    endtask : t_scan_order

    task automatic t_scan_stop;
        logic [6:0] s;
        cmp7("stopped strobes", 7'h3F, strobe_n);
        prog_table = 56'h40_0000_0000_0000;
        step(s);
        cmp7("held strobes", 7'h3F, s);
        step(s);
        cmp7("held strobes", 7'h3F, s);
        cmp7("held c1 prog", 7'h07, {3'h0, c1_prog});
        $display("test scan stop done, failures %0d", n_fail);
    endtask : t_scan_stop

    task automatic t_slave;
        load(56'h40_0000_00BA_0000);
        cmp7("slave on", 7'h01, {6'h00, slave});
        load(56'h40_0000_10BA_0000);
        cmp7("slave off", 7'h00, {6'h00, slave});
        $display("test slave done, failures %0d", n_fail);
    endtask : t_slave

    // Counts what happens up to and including the next slow falling edge.
    task automatic slow_fall(output int cyc, output int ff, output int sy, output int fb);
        logic ps;
        logic pf;
        logic py;
        cyc = 0;
        ff  = 0;
        sy  = 0;
        fb  = 0;
        ps  = slow_n;
        pf  = fast_n;
        py  = sync_n;
        while (cyc < 20000) begin
            @(negedge core_clk);
            cyc++;
            if (pf === 1'b1 && fast_n === 1'b0) ff++;
            if (py === 1'b1 && sync_n === 1'b0) sy++;
            if (cyc == 8 && fb1_n === 1'b0) fb++;
            if (ps === 1'b1 && slow_n === 1'b0) break;
            ps = slow_n;
            pf = fast_n;
            py = sync_n;
        end
    endtask : slow_fall

    // Digits n0 = 1 and n2 = 1 give a basic period of ten times m input ticks.
    task automatic t_divider(input logic [55:0] tbl, input int m);
        int cyc;
        int ff;
        int sy;
        int fb;
        int fb_sum;
        load(tbl);
        div_run = 1'b1;
        fb_sum  = 0;
        slow_fall(cyc, ff, sy, fb);
        for (int p = 0; p < m; p++) begin
            slow_fall(cyc, ff, sy, fb);
            cmp_int("slow period", 40 * m, cyc);
            cmp_int("fast pulses", m, ff);
            cmp_int("sync pulses", 1, sy);
            fb_sum += fb;
        end
        cmp_int("first strobe periods", 1, fb_sum);
        div_run = 1'b0;
        $display("test divider m %0d done, failures %0d", m, n_fail);
    endtask : t_divider

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk   = 1'b0;
        rst_n      = 1'b0;
        step_clk   = 1'b0;
        scan_en    = 1'b0;
        borrow_in  = 1'b0;
        cascade_n  = 1'b1;
        divider_in = 1'b0;
        div_run    = 1'b0;
        div_ph     = 2'd0;
        prog_table = 56'h00_0000_0000_0000;
        n_fail     = 0;
        tests_run  = 0;
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (5) @(negedge core_clk);
        t_reset();
        t_scan_order();
        t_scan_stop();
        t_slave();
        t_divider(56'h40_0000_0010_0010, 4);
        t_divider(56'h00_0000_0010_0010, 16);
        give_verdict();
    end

    // Whole run needs about 16000 cycles; this leaves ample margin.
    initial begin
        repeat (80000) @(posedge core_clk);
        n_fail++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule : dpl_loader_test

// ---- verif/dpl_prog_source.sv ----
// Programme source memory model that answers the fetch strobes of the loader.
`timescale 1ns/1ps
module dpl_prog_source (
    // Fetch address from the loader
    input  wire logic [6:0]  fetch_strobe_n,
    // Seven bytes, operand A in the high nibble of each
    input  wire logic [55:0] prog_table,
    // Operand pins, active low
    output logic      [3:0]  operand_a_nibble,
    output logic      [3:0]  operand_b_nibble
);
    logic [3:0] last_a;
    logic [3:0] last_b;
    int         sel;

    ////////////////////////////////////////////////////////////////////////////////
    // Between fetches the pins show the inverse of the last byte, so stale data never passes.
    always @(fetch_strobe_n or prog_table) begin
        sel = -1;
        for (int k = 0; k < 7; k++) begin
            if (fetch_strobe_n[k] === 1'b0) begin
                sel = k;
            end
        end
        if (sel >= 0) begin
            last_a           = prog_table[8*sel+4 +: 4];
            last_b           = prog_table[8*sel +: 4];
            operand_a_nibble = ~last_a;
            operand_b_nibble = ~last_b;
        end else begin
            operand_a_nibble = last_a;
            operand_b_nibble = last_b;
        end
    end
endmodule : dpl_prog_source
